// file: pkg/ast_cfg.svh
// Constants for the serial transceiver: offsets, fields, reset values, counts.
`ifndef AST_CFG_SVH
`define AST_CFG_SVH
`define AST_OFF_DATA 32'h0000_0000
`define AST_OFF_CTRL 32'h0000_0004
`define AST_M_FAC_LO 0
`define AST_M_FAC_HI 1
`define AST_M_LEN_LO 2
`define AST_M_LEN_HI 3
`define AST_M_PEN 4
`define AST_M_PEVEN 5
`define AST_M_STOP_LO 6
`define AST_M_STOP_HI 7
`define AST_M_EXT 6
`define AST_M_SINGLE 7
`define AST_FAC_SYNC 2'h0
`define AST_FAC_X1 2'h1
`define AST_FAC_X16 2'h2
`define AST_STOP_1 2'h1
`define AST_STOP_15 2'h2
`define AST_C_TRANSMIT_ENABLE_BIT 0
`define AST_C_RXEN 2
`define AST_C_BRK 3
`define AST_C_ERST 4
`define AST_C_IRST 6
`define AST_C_HUNT 7
`define AST_S_TRANSMIT_READY_OUT 0
`define AST_S_RXAV 1
`define AST_S_TXEMP 2
`define AST_S_PE 3
`define AST_S_OE 4
`define AST_S_FE 5
`define AST_S_SYN 6
`define AST_S_DSR 7
`define AST_DIV_X1 7'h01
`define AST_DIV_X16 7'h10
`define AST_DIV_X64 7'h40
`define AST_CNT_ONE 4'h1
`define AST_DIV_ONE 7'h01
`define AST_LEN_BASE 4'h5
`define AST_DATA_W 4'h8
`define AST_RSH_W 4'h9
`define AST_RSH_ONES 9'h1ff
`define AST_TSH_ONES 12'hfff
`define AST_BYTE_ONES 8'hff
`define AST_HI_ZERO 24'h00_0000
`endif

// file: pkg/ast_pkg.sv
// Types shared by the serial transceiver: sequencing states and the state record.
package ast_pkg;
  typedef enum logic [3:0] {
    PH_MODE = 4'h1,
    PH_SYN1 = 4'h2,
    PH_SYN2 = 4'h4,
    PH_CMD = 4'h8
  } ast_phase_t;
  typedef enum logic [5:0] {
    RX_IDLE = 6'h01,
    RX_START = 6'h02,
    RX_DATA = 6'h04,
    RX_HUNT = 6'h08,
    RX_HUNT2 = 6'h10,
    RX_SYNC = 6'h20
  } ast_rx_t;
  typedef struct packed {
    ast_phase_t phase;
    ast_rx_t rst;
    logic [7:0] mode, cmd, sync1, sync2, tbuf, rbuf, stat;
    logic tfull, tbusy, tstarted, tsel, tempty, tline, txd, rdy;
    logic [11:0] tsh;
    logic [3:0] tcnt, rbit;
    logic [6:0] tdiv, rdiv;
    logic txc_q, rxc_q, rxd_q;
    logic [8:0] rsh;
    logic avail, pe, oe, fe, syn, prev1, soe, ack;
    logic [31:0] dat;
  } ast_state_t;
endpackage

// file: rtl/ast_transceiver.sv
// Asynchronous and character-synchronous serial transceiver with a Wishbone slave.
//
// Local design decisions: the register addresses and the Wishbone slave port.
`include "ast_cfg.svh"

// Behaviour
// - Async frame: start, data LSB first, parity, stops.
// - Async bits change on falling clock, divided.
// - Async idle line high; break holds low.
// - Falling edge starts; recheck at centre (16x/64x).
// - Rising receive clock samples; counter finds centres.
// - Parity mismatch sets parity error flag.
// - Only first stop checked; low sets framing error.
// - Completed character loads buffer, raises available.
// - Unfetched character overwritten, overrun flag set.
// - Error reset clears flags; errors never stop reception.
// - Sync output high until first character, clear-to-send.
// - Sync underrun inserts sync characters, raises empty.
// - Sync empty stays high until data written.
// - Hunt compares first sync each bit, then second.
// - Internal sync drives detect; status read clears.
// - External high on detect pin ends hunt.
// - Enter hunt fills buffer with ones; async ignores.
// - Sync parity checked whenever not hunting.
// - Synced detection only at character boundaries.
// - After mode and syncs, control writes load command.
// - Status read returns status, holds updates meanwhile.
// - Ready pin needs empty, clear-to-send, enable.
// - Receive disabled masks and holds available low.
module ast_transceiver (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic transmit_bit_clock_i,
  input wire logic receive_bit_clock_i,
  output logic txd_o,
  input wire logic rxd_i,
  input wire logic cts_n_i,
  output logic transmit_ready_out_o,
  output logic transmitter_empty_out_o,
  output logic receive_char_available_o,
  input wire logic sync_detect_pin_i,
  output logic sync_detect_pin_o,
  output logic sync_detect_pin_oe_o
);
  import ast_pkg::*;

  ast_state_t s, n;
  logic acc, a_data, a_ctrl, wr, stat_rd, stat_busy, live;
  logic tx_tick, rx_tick, asy, ext, single, pen, podd, transmit_enable_bit, rxen;
  logic can_data, bdone, half, rat, deliver, perr, m1, m2;
  logic [1:0] stop;
  logic [3:0] len, rn, tcount, ntc;
  logic [6:0] fac;
  logic [7:0] src, rdat, st;
  logic [8:0] rwin;
  logic [11:0] frame;

  function automatic logic [7:0] lmask(input logic [3:0] l);
    lmask = `AST_BYTE_ONES >> (`AST_DATA_W - l);
  endfunction

  // Builds the line image of one character, first bit in position zero.
  function automatic logic [11:0] build(input logic [7:0] d, input logic [3:0] l,
                                        input logic pe_on, input logic odd,
                                        input logic a);
    logic [11:0] f;
    logic [3:0] k;
    f = `AST_TSH_ONES;
    k = 4'h0;
    if (a) begin
      f[0] = 1'b0;
      k = `AST_CNT_ONE;
    end
    for (int i = 0; i < 8; i++) begin
      if (i[3:0] < l) begin
        f[k + i[3:0]] = d[i];
      end
    end
    if (pe_on) begin
      f[k + l] = ^(d & lmask(l)) ^ odd;
    end
    build = f;
  endfunction

  function automatic ast_state_t rst_val();
    ast_state_t r;
    r = '0;
    r.phase = PH_MODE;
    r.rst = RX_IDLE;
    r.tline = 1'b1;
    r.txd = 1'b1;
    r.tempty = 1'b1;
    r.soe = 1'b1;
    r.rxd_q = 1'b1;
    r.rsh = `AST_RSH_ONES;
    r.stat[`AST_S_TRANSMIT_READY_OUT] = 1'b1;
    r.stat[`AST_S_TXEMP] = 1'b1;
    rst_val = r;
  endfunction

  always_comb begin
    n = s;
    n.txc_q = transmit_bit_clock_i;
    n.rxc_q = receive_bit_clock_i;
    live = s.phase == PH_CMD;
    tx_tick = live & s.txc_q & ~transmit_bit_clock_i;
    rx_tick = live & ~s.rxc_q & receive_bit_clock_i;
    acc = wb_cyc_i & wb_stb_i & ~s.ack;
    a_data = wb_adr_i == `AST_OFF_DATA;
    a_ctrl = wb_adr_i == `AST_OFF_CTRL;
    wr = acc & wb_we_i & wb_sel_i[0];
    stat_rd = acc & ~wb_we_i & a_ctrl;
    stat_busy = wb_cyc_i & wb_stb_i & ~wb_we_i & a_ctrl;
    n.ack = acc;
    n.dat = 32'h0;
    asy = s.mode[`AST_M_FAC_HI:`AST_M_FAC_LO] != `AST_FAC_SYNC;
    ext = s.mode[`AST_M_EXT];
    single = s.mode[`AST_M_SINGLE];
    pen = s.mode[`AST_M_PEN];
    podd = ~s.mode[`AST_M_PEVEN];
    stop = s.mode[`AST_M_STOP_HI:`AST_M_STOP_LO];
    transmit_enable_bit = s.cmd[`AST_C_TRANSMIT_ENABLE_BIT];
    rxen = s.cmd[`AST_C_RXEN];
    len = {2'h0, s.mode[`AST_M_LEN_HI:`AST_M_LEN_LO]} + `AST_LEN_BASE;
    rn = len + {3'h0, pen};
    unique case (s.mode[`AST_M_FAC_HI:`AST_M_FAC_LO])
      `AST_FAC_SYNC, `AST_FAC_X1: fac = `AST_DIV_X1;
      `AST_FAC_X16: fac = `AST_DIV_X16;
      default: fac = `AST_DIV_X64;
    endcase
    tcount = (asy ? `AST_CNT_ONE : 4'h0) + rn;
    if (asy) begin
      tcount = tcount + ((stop == `AST_STOP_1) ? `AST_CNT_ONE : 4'h2);
    end
    deliver = 1'b0;
    src = 8'h0;
    frame = `AST_TSH_ONES;
    // Host reads; clears go first so that a same-cycle event still sets.
    if (acc & ~wb_we_i & a_data) begin
      n.dat = {`AST_HI_ZERO, s.rbuf};
      n.avail = 1'b0;
    end
    if (stat_rd) begin
      n.dat = {`AST_HI_ZERO, s.stat};
      n.syn = 1'b0;
    end
    if (wr & a_ctrl & live & wb_dat_i[`AST_C_ERST]) begin
      n.pe = 1'b0;
      n.oe = 1'b0;
      n.fe = 1'b0;
    end
    if (wr & a_data & live & ~asy) begin
      n.tempty = 1'b0;
    end
    // Transmitter.
    can_data = s.tfull & transmit_enable_bit & ~cts_n_i;
    bdone = s.tbusy & (s.tdiv == `AST_DIV_ONE);
    ntc = s.tcnt - `AST_CNT_ONE;
    half = asy & (stop == `AST_STOP_15) & (fac != `AST_DIV_X1) & (ntc == `AST_CNT_ONE);
    if (tx_tick) begin
      if (s.tbusy & ~bdone) begin
        n.tdiv = s.tdiv - `AST_DIV_ONE;
      end else if (s.tbusy & (s.tcnt != `AST_CNT_ONE)) begin
        n.tsh = {1'b1, s.tsh[11:1]};
        n.tcnt = ntc;
        n.tline = s.tsh[1];
        n.tdiv = half ? (fac >> 1) : fac;
      end else begin
        n.tbusy = 1'b0;
        n.tline = 1'b1;
        if (can_data | (~asy & s.tstarted)) begin
          src = can_data ? s.tbuf : (s.tsel ? s.sync2 : s.sync1);
          frame = build(src, len, pen, podd, asy);
          n.tsh = frame;
          n.tcnt = tcount;
          n.tline = frame[0];
          n.tdiv = fac;
          n.tbusy = 1'b1;
          if (can_data) begin
            n.tfull = 1'b0;
            n.tstarted = ~asy;
            n.tsel = 1'b0;
          end else begin
            n.tempty = 1'b1;
            n.tsel = ~single & ~s.tsel;
          end
        end
      end
    end
    // Receiver: sync mode shifts every bit except while the external detect pin ends a hunt, async only at bit centres.
    if (rx_tick) begin
      n.rxd_q = rxd_i;
      if (~asy & ~((s.rst == RX_HUNT) & ext & sync_detect_pin_i)) begin
        n.rsh = {rxd_i, s.rsh[8:1]};
      end
    end
    rwin = n.rsh >> (`AST_RSH_W - rn);
    rdat = rwin[7:0] & lmask(len);
    perr = pen & (rwin[len] != (^rdat ^ podd));
    m1 = rdat == (s.sync1 & lmask(len));
    m2 = rdat == (s.sync2 & lmask(len));
    rat = s.rdiv == `AST_DIV_ONE;
    if (rx_tick) begin
      unique case (s.rst)
        RX_IDLE: begin
          if (asy & s.rxd_q & ~rxd_i) begin
            n.rbit = 4'h0;
            n.rst = (fac == `AST_DIV_X1) ? RX_DATA : RX_START;
            n.rdiv = (fac == `AST_DIV_X1) ? `AST_DIV_ONE : (fac >> 1);
          end
        end
        RX_START: begin
          if (~rat) begin
            n.rdiv = s.rdiv - `AST_DIV_ONE;
          end else begin
            n.rdiv = fac;
            n.rst = rxd_i ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (~rat) begin
            n.rdiv = s.rdiv - `AST_DIV_ONE;
          end else if (s.rbit != rn) begin
            n.rdiv = fac;
            n.rsh = {rxd_i, s.rsh[8:1]};
            n.rbit = s.rbit + `AST_CNT_ONE;
          end else begin
            n.fe = n.fe | ~rxd_i;
            deliver = 1'b1;
            n.rst = RX_IDLE;
          end
        end
        RX_HUNT: begin
          n.rbit = 4'h0;
          if (ext) begin
            if (sync_detect_pin_i) begin
              n.rst = RX_SYNC;
            end
          end else if (m1) begin
            n.rst = single ? RX_SYNC : RX_HUNT2;
            n.syn = n.syn | single;
          end
        end
        RX_HUNT2: begin
          n.rbit = s.rbit + `AST_CNT_ONE;
          if (n.rbit == rn) begin
            n.rbit = 4'h0;
            n.rst = m2 ? RX_SYNC : RX_HUNT;
            n.syn = n.syn | m2;
          end
        end
        RX_SYNC: begin
          n.rbit = s.rbit + `AST_CNT_ONE;
          if (n.rbit == rn) begin
            n.rbit = 4'h0;
            deliver = 1'b1;
            n.prev1 = m1;
            if (~ext & (single ? m1 : (s.prev1 & m2))) begin
              n.syn = 1'b1;
            end
          end
        end
        default: n.rst = RX_IDLE;
      endcase
      if (~asy & ext & sync_detect_pin_i) begin
        n.syn = 1'b1;
      end
    end
    if (deliver) begin
      n.pe = n.pe | perr;
      if (rxen) begin
        n.rbuf = rdat;
        n.oe = n.oe | s.avail;
        n.avail = 1'b1;
      end
    end
    if (~rxen) begin
      n.avail = 1'b0;
    end
    // Host writes to the data and control locations.
    if (wr & a_data & live) begin
      n.tbuf = wb_dat_i[7:0];
      n.tfull = 1'b1;
    end
    if (wr & a_ctrl) begin
      unique case (s.phase)
        PH_MODE: begin
          n.mode = wb_dat_i[7:0];
          if (wb_dat_i[`AST_M_FAC_HI:`AST_M_FAC_LO] == `AST_FAC_SYNC) begin
            n.phase = PH_SYN1;
            n.rst = RX_HUNT;
            n.soe = ~wb_dat_i[`AST_M_EXT];
          end else begin
            n.phase = PH_CMD;
          end
        end
        PH_SYN1: begin
          n.sync1 = wb_dat_i[7:0];
          n.phase = single ? PH_CMD : PH_SYN2;
        end
        PH_SYN2: begin
          n.sync2 = wb_dat_i[7:0];
          n.phase = PH_CMD;
        end
        PH_CMD: begin
          n.cmd = wb_dat_i[7:0];
          if (wb_dat_i[`AST_C_HUNT] & ~asy) begin
            n.rst = RX_HUNT;
            n.rsh = `AST_RSH_ONES;
          end
        end
        default: n.phase = PH_MODE;
      endcase
    end
    n.txd = (asy & n.cmd[`AST_C_BRK]) ? 1'b0 : n.tline;
    n.rdy = ~n.tfull & ~cts_n_i & n.cmd[`AST_C_TRANSMIT_ENABLE_BIT];
    if (asy) begin
      n.tempty = ~n.tfull & ~n.tbusy;
    end
    st = 8'h0;
    st[`AST_S_TRANSMIT_READY_OUT] = ~n.tfull;
    st[`AST_S_RXAV] = n.avail;
    st[`AST_S_TXEMP] = n.tempty;
    st[`AST_S_PE] = n.pe;
    st[`AST_S_OE] = n.oe;
    st[`AST_S_FE] = n.fe;
    st[`AST_S_SYN] = n.syn;
    st[`AST_S_DSR] = 1'b0;
    if (~stat_busy) begin
      n.stat = st;
    end
    if (rst_i | (wr & a_ctrl & live & wb_dat_i[`AST_C_IRST])) begin
      n = rst_val();
      n.ack = acc & ~rst_i;
    end
  end

  always_ff @(posedge clk_i) begin
    s <= n;
  end

  assign wb_dat_o = s.dat;
  assign wb_ack_o = s.ack;
  assign txd_o = s.txd;
  assign transmit_ready_out_o = s.rdy;
  assign transmitter_empty_out_o = s.tempty;
  assign receive_char_available_o = s.avail;
  assign sync_detect_pin_o = s.syn;
  assign sync_detect_pin_oe_o = s.soe;
endmodule // ast_transceiver

// file: sim/ast_sva.sv
// Bus and line checks for the serial transceiver.
module ast_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic transmit_bit_clock_i,
  input wire logic txd_o,
  input wire logic cts_n_i,
  input wire logic transmit_ready_out_o,
  input wire logic transmitter_empty_out_o,
  input wire logic receive_char_available_o,
  input wire logic sync_detect_pin_o,
  input wire logic sync_detect_pin_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic tx_q;
  logic [3:0] sf, sa;
  // Cycles since the last transmit tick and the last bus request, saturating.
  always_ff @(posedge clk_i) begin
    tx_q <= transmit_bit_clock_i;
    sf <= (tx_q && !transmit_bit_clock_i) ? 4'h0 : sf + {3'h0, sf != 4'hf};
    sa <= (wb_cyc_i && wb_stb_i) ? 4'h0 : sa + {3'h0, sa != 4'hf};
  end
  property p_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_take: assert property (p_take) else $error("ack late");
  property p_one;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_one: assert property (p_one) else $error("ack too long");
  property p_idle;
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
  endproperty
  a_idle: assert property (p_idle) else $error("ack without request");
  property p_hi;
    wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000;
  endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_unm;
    wb_ack_o && wb_adr_i != 32'h0 && wb_adr_i != 32'h4 |-> wb_dat_o == 32'h0;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_rst;
    $fell(rst_i) |-> txd_o && transmitter_empty_out_o && !receive_char_available_o &&
      !transmit_ready_out_o && sync_detect_pin_oe_o && !sync_detect_pin_o && !wb_ack_o;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_cts;
    cts_n_i && $past(cts_n_i) && $past(cts_n_i, 2) |-> !transmit_ready_out_o;
  endproperty
  a_cts: assert property (p_cts) else $error("ready with cts high");
  property p_tick;
    $changed(txd_o) |-> sf <= 4'h4 || sa <= 4'h4;
  endproperty
  a_tick: assert property (p_tick) else $error("txd moved off tick");
endmodule // ast_sva

// file: sim/ast_line_model.sv
// Serial terminal model: bit clock, frame sender and frame catcher.
module ast_line_model (
  output logic bit_clk_o,
  output logic rxd_o,
  output logic sync_o,
  input wire logic txd_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    bit_clk_o = 1'b1;
    forever #20 bit_clk_o = ~bit_clk_o;
  end
  initial begin
    rxd_o = 1'b1;
    sync_o = 1'b0;
  end
  // Sends start, data LSB first, parity and stop, 16 ticks a bit.
  task automatic send(input logic [7:0] d, input logic par, input logic stp);
    logic [10:0] fr;
    fr = {stp, par, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd_o <= fr[i];
      repeat (16) @(negedge bit_clk_o);
    end
    rxd_o <= 1'b1;
    @(negedge bit_clk_o);
  endtask
  // Shifts one character LSB first, one bit per clock, changing on the falling edge.
  task automatic sync_send(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(negedge bit_clk_o);
      rxd_o <= d[i];
    end
  endtask
  // Holds the sync strobe high for one clock, then shifts a character right behind it.
  task automatic ext_send(input logic [7:0] d);
    @(negedge bit_clk_o);
    sync_o <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(negedge bit_clk_o);
      sync_o <= 1'b0;
      rxd_o <= d[i];
    end
  endtask
  // Waits for a start bit, then samples each bit at its centre.
  task automatic grab(output logic [10:0] fr);
    int n;
    n = 0;
    while (txd_i !== 1'b0 && n < 2000) begin
      @(posedge bit_clk_o);
      n++;
    end
    repeat (8) @(posedge bit_clk_o);
    for (int i = 0; i < 11; i++) begin
      fr[i] = txd_i;
      repeat (16) @(posedge bit_clk_o);
    end
  endtask
endmodule // ast_line_model

// file: sim/ast_transceiver_tb.sv
// Self-checking bench for the serial transceiver.
module ast_transceiver_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, cyc, stb, we, cts_n, bclk, rxd, ack, txd, rdy, temp, rxav, sdo, sdoe;
  logic [3:0] sel;
  logic [31:0] adr, wdat, rdat;
  logic [7:0] q;
  logic xsync;
  logic [10:0] f;
  int err_total, n_checks;
  ast_transceiver u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .transmit_bit_clock_i(bclk), .receive_bit_clock_i(bclk), .txd_o(txd),
    .rxd_i(rxd), .cts_n_i(cts_n), .transmit_ready_out_o(rdy), .transmitter_empty_out_o(temp),
    .receive_char_available_o(rxav), .sync_detect_pin_i(sdoe ? sdo : xsync),
    .sync_detect_pin_o(sdo), .sync_detect_pin_oe_o(sdoe));
  ast_line_model m (.bit_clk_o(bclk), .rxd_o(rxd), .sync_o(xsync), .txd_i(txd));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // One classic cycle; read data lands in q.
  task automatic wb(input logic w, input logic [31:0] a, input logic [7:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    wdat <= {24'h00_0000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      err_total++;
      final_report();
    end
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic st(input logic [7:0] e);
    repeat (30) @(posedge clk_i);
    wb(1'b0, 32'h4, 8'h00);
    chk("status", {3'h0, e}, {3'h0, q});
  endtask
  task automatic t_init();
    wb(1'b1, 32'h8, 8'h5a);
    wb(1'b0, 32'h8, 8'h00);
    chk("unmapped", 11'h000, {3'h0, q});
    wb(1'b1, 32'h4, 8'h7e);
    wb(1'b1, 32'h4, 8'h15);
    st(8'h05);
    chk("ready pin", 11'h001, {10'h000, rdy});
  endtask
  task automatic t_tx();
    fork
      m.grab(f);
      wb(1'b1, 32'h0, 8'hb3);
    join
    chk("frame", {1'b1, 1'b1, 8'hb3, 1'b0}, f);
  endtask
  task automatic t_rx();
    m.send(8'h3c, 1'b0, 1'b1);
    repeat (30) @(posedge clk_i);
    chk("avail pin", 11'h001, {10'h000, rxav});
    wb(1'b0, 32'h0, 8'h00);
    chk("rx data", 11'h03c, {3'h0, q});
    st(8'h05);
  endtask
  task automatic t_err();
    m.send(8'h11, 1'b0, 1'b1);
    m.send(8'h22, 1'b1, 1'b0);
    st(8'h3f);
    wb(1'b0, 32'h0, 8'h00);
    chk("overwrite", 11'h022, {3'h0, q});
    wb(1'b1, 32'h4, 8'h15);
    st(8'h05);
  endtask
  task automatic t_brk();
    wb(1'b1, 32'h4, 8'h01);
    m.send(8'h55, 1'b0, 1'b1);
    repeat (30) @(posedge clk_i);
    chk("avail masked", 11'h000, {10'h000, rxav});
    cts_n <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk("ready cts", 11'h000, {10'h000, rdy});
    cts_n <= 1'b0;
    wb(1'b1, 32'h4, 8'h09);
    repeat (30) @(posedge clk_i);
    chk("break", 11'h000, {10'h000, txd});
    wb(1'b1, 32'h4, 8'h40);
    repeat (4) @(posedge clk_i);
    chk("idle after reset", 11'h001, {10'h000, txd});
    chk("ready after reset", 11'h000, {10'h000, rdy});
    wb(1'b1, 32'h4, 8'h7e);
    wb(1'b1, 32'h4, 8'h15);
    st(8'h05);
  endtask
  // Single internal sync character, eight bits, no parity, one bit per clock.
  task automatic t_sync();
    wb(1'b1, 32'h4, 8'h40);
    wb(1'b1, 32'h4, 8'h8c);
    wb(1'b1, 32'h4, 8'h16);
    wb(1'b1, 32'h4, 8'h95);
    repeat (20) @(posedge clk_i);
    chk("sync idle line", 11'h001, {10'h000, txd});
    wb(1'b1, 32'h0, 8'h3c);
    chk("tx empty low", 11'h000, {10'h000, temp});
    m.sync_send(8'h16);
    m.sync_send(8'ha5);
    repeat (8) @(posedge clk_i);
    chk("sync pin", 11'h001, {10'h000, sdo});
    chk("sync avail", 11'h001, {10'h000, rxav});
    chk("tx empty high", 11'h001, {10'h000, temp});
    wb(1'b0, 32'h0, 8'h00);
    chk("sync data", 11'h0a5, {3'h0, q});
    st(8'h45);
    chk("sync pin cleared", 11'h000, {10'h000, sdo});
    repeat (80) @(posedge clk_i);
    chk("still in sync", 11'h001, {10'h000, rxav});
    chk("tx empty held", 11'h001, {10'h000, temp});
  endtask
  // External sync: the strobe on the detect pin ends the hunt.
  task automatic t_ext();
    wb(1'b1, 32'h4, 8'h40);
    wb(1'b1, 32'h4, 8'hcc);
    wb(1'b1, 32'h4, 8'h16);
    wb(1'b1, 32'h4, 8'h95);
    chk("pin direction", 11'h000, {10'h000, sdoe});
    m.sync_send(8'h16);
    repeat (8) @(posedge clk_i);
    chk("no internal detect", 11'h000, {10'h000, sdo});
    m.ext_send(8'h5a);
    repeat (8) @(posedge clk_i);
    chk("ext flag", 11'h001, {10'h000, sdo});
    wb(1'b0, 32'h0, 8'h00);
    chk("ext data", 11'h05a, {3'h0, q});
  endtask
  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    sel = 4'h0;
    adr = 32'h0;
    wdat = 32'h0;
    cts_n = 1'b0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_init();
    t_tx();
    t_rx();
    t_err();
    t_brk();
    t_sync();
    t_ext();
    final_report();
  end
endmodule // ast_transceiver_tb
bind ast_transceiver ast_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .transmit_bit_clock_i(transmit_bit_clock_i), .txd_o(txd_o), .cts_n_i(cts_n_i),
  .transmit_ready_out_o(transmit_ready_out_o),
  .transmitter_empty_out_o(transmitter_empty_out_o),
  .receive_char_available_o(receive_char_available_o),
  .sync_detect_pin_o(sync_detect_pin_o), .sync_detect_pin_oe_o(sync_detect_pin_oe_o));
